// ---- rtl/i2c_host_map.svh ----
// Constants of the two-wire command port: command codes, read pointer
// codes, slave address layout and link rates.
// Assumes inclusion by bare name from the port's module, its checks and its bench.
`ifndef I2C_HOST_MAP_SVH
`define I2C_HOST_MAP_SVH

// Command codes
`define DEVICE_RESET_CMD      8'hF0
`define CONFIG_WRITE_CMD      8'hD2
`define POINTER_SET_CMD       8'hE1
`define CHANNEL_CHOOSE_CMD    8'hC3
`define LINE_RESET_CMD        8'hB4
`define LINE_BYTE_WRITE_CMD   8'hA5
`define LINE_BYTE_READ_CMD    8'h96
`define LINE_SINGLE_BIT_CMD   8'h87
`define LINE_SEARCH_STEP_CMD  8'h78

// Read pointer codes
`define PTR_STATUS            8'hF0
`define PTR_LINE_DATA         8'hE1
`define PTR_CONFIG            8'hC3
`define PTR_CHANNEL           8'hD2

// Slave address: fixed upper part, pin-selected lower part (arbitrary)
`define ADDR_HI_DEFAULT       4'h3
`define ADDR_PIN_BITS         3

// Reset values and bit-count limits of link-side state
`define BIT_CNT_RESET         4'h0
`define TX_IDLE_BYTE          8'hFF
`define BYTE_LAST_BIT         4'h7
`define BYTE_BITS             4'h8

// Link rates, bits per second
`define STD_MODE_BPS          100000
`define FAST_MODE_BPS         400000

`endif

// ---- rtl/i2c_host_pkg.sv ----
// Types shared by the two-wire command port.
// Uses none of the constants of the map header.
package i2c_host_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_ACK,
      ST_TX,
      ST_MACK,
      ST_RELOAD
   } link_state_e;

   typedef enum logic [1:0] {
      ROLE_ADDR,
      ROLE_CMD,
      ROLE_PARAM,
      ROLE_SURPLUS
   } byte_role_e;

   typedef enum logic [1:0] {
      SEL_STATUS,
      SEL_LINE_DATA,
      SEL_CONFIG,
      SEL_CHANNEL
   } read_sel_e;

endpackage : i2c_host_pkg

// ---- rtl/sync2.sv ----
// Two flip-flop synchroniser for levels and toggles.
// Assumes the destination clock and its active-low async reset.
`timescale 1ns/1ps

module sync2 #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RESET_VAL;
         dout   <= RESET_VAL;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end

endmodule : sync2

// ---- rtl/i2c_host_command_port.sv ----
// Two-wire slave command port of the line bridge.
// Assumes SCL/SDA pins on the link clock side (oversampled), the line
// engine and register bytes on clk_sys, and an external open-drain pad.
//
// Overview of operation
// - Works at 100 and 400 kbit/s
// - Whole bytes, MSB first, then acknowledge slot
// - Low three address bits from address pins
// - Address last bit: 0 write, 1 read
// - START: SDA falls while SCL high
// - STOP: SDA rises while SCL high
// - Repeated START begins a new transfer
// - Data sampled on rising SCL edge
// - Transmit bits change on falling SCL edge
// - Acknowledge holds SDA low in ninth pulse
// - Refused bytes leave SDA released high
// - Master nack ends read, SDA released
// - Ack valid codes/parameters, never surplus bytes
// - Reads repeat register selected by pointer
// - Codes F0h reset, D2h config, E1h pointer
// - Codes C3h channel, B4h reset, A5h write
// - Codes 96h read, 87h bit, 78h search
// - Busy refuses configuration write code
// - Channel code E1h accepted, E5h refused
// - Busy: codes other than F0h and E1h not acked and ignored
// - Pointer code C3h accepted, E5h refused
// - SCL is input only, no stretching
`timescale 1ns/1ps

`include "i2c_host_map.svh"

module i2c_host_command_port
   import i2c_host_pkg::*;
#(
   parameter logic [3:0] ADDR_HI = `ADDR_HI_DEFAULT
) (
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic       clk_link,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   input  wire logic       addr_select_pin_0,
   input  wire logic       addr_select_pin_1,
   input  wire logic       addr_select_pin_2,
   input  wire logic       line_busy_flag,
   input  wire logic [7:0] status_byte,
   input  wire logic [7:0] line_data_byte,
   input  wire logic [7:0] config_byte,
   input  wire logic [7:0] channel_byte,
   output logic            cmd_valid,
   output logic [7:0]      cmd_code,
   output logic [7:0]      cmd_param
);

   // Link side signals
   logic        link_rst_n;
   logic        scl_s;
   logic        sda_s;
   logic        busy_l;
   logic [2:0]  pins_l;
   logic        scl_d_r;
   logic        sda_d_r;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   link_state_e state_r;
   byte_role_e  role_r;
   logic [3:0]  bit_cnt_r;
   logic [7:0]  shreg_r;
   logic [7:0]  tx_sh_r;
   logic [7:0]  tx_hold_r;
   logic        ack_phase_r;
   logic        tx_mode_r;
   logic [7:0]  cmd_r;
   read_sel_e   ptr_r;
   logic        oe_n_r;
   logic        cmd_tgl_r;
   logic [7:0]  cmd_code_l_r;
   logic [7:0]  cmd_param_l_r;
   logic        rd_req_tgl_r;
   logic        rd_ack_s;
   logic        rd_ack_seen_r;
   logic [7:0]  rx_byte;
   logic        byte_done;

   // Decisions on a completed byte
   logic        acc;
   byte_role_e  role_n;
   logic        tx_n;
   logic        emit;
   logic        ptr_load;
   read_sel_e   ptr_n;

   // System side signals
   logic        cmd_tgl_s;
   logic        rd_req_s;
   logic        cmd_tgl_d_r;
   logic        rd_req_d_r;
   logic [7:0]  rd_data_r;
   logic        rd_ack_tgl_r;
   logic        cmd_valid_r;
   logic [7:0]  cmd_code_r;
   logic [7:0]  cmd_param_r;

   function automatic logic code_known(input logic [7:0] c);
      unique case (c)
         `DEVICE_RESET_CMD,
         `CONFIG_WRITE_CMD,
         `POINTER_SET_CMD,
         `CHANNEL_CHOOSE_CMD,
         `LINE_RESET_CMD,
         `LINE_BYTE_WRITE_CMD,
         `LINE_BYTE_READ_CMD,
         `LINE_SINGLE_BIT_CMD,
         `LINE_SEARCH_STEP_CMD: code_known = 1'b1;
         default:               code_known = 1'b0;
      endcase
   endfunction : code_known

   function automatic logic needs_param(input logic [7:0] c);
      needs_param = (c == `CONFIG_WRITE_CMD) ||
                    (c == `POINTER_SET_CMD) ||
                    (c == `CHANNEL_CHOOSE_CMD) ||
                    (c == `LINE_BYTE_WRITE_CMD) ||
                    (c == `LINE_SINGLE_BIT_CMD) ||
                    (c == `LINE_SEARCH_STEP_CMD);
   endfunction : needs_param

   // Commands still taken while the line is busy
   function automatic logic busy_exempt(input logic [7:0] c);
      busy_exempt = (c == `DEVICE_RESET_CMD) || (c == `POINTER_SET_CMD);
   endfunction : busy_exempt

   function automatic logic ptr_code_ok(input logic [7:0] p);
      ptr_code_ok = (p == `PTR_STATUS) || (p == `PTR_LINE_DATA) ||
                    (p == `PTR_CONFIG) || (p == `PTR_CHANNEL);
   endfunction : ptr_code_ok

   function automatic read_sel_e ptr_decode(input logic [7:0] p);
      if (p == `PTR_LINE_DATA) begin
         ptr_decode = SEL_LINE_DATA;
      end else if (p == `PTR_CONFIG) begin
         ptr_decode = SEL_CONFIG;
      end else if (p == `PTR_CHANNEL) begin
         ptr_decode = SEL_CHANNEL;
      end else begin
         ptr_decode = SEL_STATUS;
      end
   endfunction : ptr_decode

   // Config and channel bytes: upper nibble must complement the lower; channel also needs bit 3 clear
   function automatic logic param_ok(input logic [7:0] c,
                                     input logic [7:0] p);
      if (c == `CHANNEL_CHOOSE_CMD) begin
         param_ok = (p[7:4] == ~p[3:0]) && !p[3];
      end else if (c == `CONFIG_WRITE_CMD) begin
         param_ok = (p[7:4] == ~p[3:0]);
      end else if (c == `POINTER_SET_CMD) begin
         param_ok = ptr_code_ok(p);
      end else begin
         param_ok = 1'b1;
      end
   endfunction : param_ok

   // Link clock reset release and pin synchronisers
   sync2 #(
      .WIDTH     (1),
      .RESET_VAL (1'b0)
   ) u_link_rst (
      .clk   (clk_link),
      .rst_n (nrst),
      .din   (1'b1),
      .dout  (link_rst_n)
   );

   // Oversampling at the link clock covers both bus rates
   sync2 #(
      .WIDTH     (2),
      .RESET_VAL (2'b11)
   ) u_bus_sync (
      .clk   (clk_link),
      .rst_n (link_rst_n),
      .din   ({scl_in, sda_in}),
      .dout  ({scl_s, sda_s})
   );

   sync2 #(
      .WIDTH     (5),
      .RESET_VAL (5'h00)
   ) u_misc_sync (
      .clk   (clk_link),
      .rst_n (link_rst_n),
      .din   ({line_busy_flag, addr_select_pin_2, addr_select_pin_1,
               addr_select_pin_0, rd_ack_tgl_r}),
      .dout  ({busy_l, pins_l, rd_ack_s})
   );

   always_ff @(posedge clk_link or negedge link_rst_n) begin
      if (!link_rst_n) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // Bus conditions; SCL is only ever sampled
   assign scl_rise  = scl_s & ~scl_d_r;
   assign scl_fall  = ~scl_s & scl_d_r;
   assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

   assign rx_byte   = {shreg_r[6:0], sda_s};
   assign byte_done = (state_r == ST_RX) && scl_rise &&
                      (bit_cnt_r == `BYTE_LAST_BIT);

   always_comb begin
      acc      = 1'b0;
      role_n   = ROLE_SURPLUS;
      tx_n     = 1'b0;
      emit     = 1'b0;
      ptr_load = 1'b0;
      ptr_n    = ptr_r;
      unique case (role_r)
         ROLE_ADDR: begin
            if (rx_byte[7:1] == {ADDR_HI, pins_l}) begin
               acc    = 1'b1;
               tx_n   = rx_byte[0];
               role_n = ROLE_CMD;
            end
         end
         ROLE_CMD: begin
            if (code_known(rx_byte) &&
                (!busy_l || busy_exempt(rx_byte))) begin
               acc = 1'b1;
               if (needs_param(rx_byte)) begin
                  role_n = ROLE_PARAM;
               end else begin
                  emit = 1'b1;
                  if (rx_byte == `DEVICE_RESET_CMD) begin
                     ptr_load = 1'b1;
                     ptr_n    = SEL_STATUS;
                  end
               end
            end
         end
         ROLE_PARAM: begin
            if (param_ok(cmd_r, rx_byte)) begin
               acc = 1'b1;
               if (cmd_r == `POINTER_SET_CMD) begin
                  ptr_load = 1'b1;
                  ptr_n    = ptr_decode(rx_byte);
               end else begin
                  emit = 1'b1;
               end
            end
         end
         ROLE_SURPLUS: begin
            acc = 1'b0;
         end
      endcase
   end

   // Byte engine
   always_ff @(posedge clk_link or negedge link_rst_n) begin
      if (!link_rst_n) begin
         state_r     <= ST_IDLE;
         role_r      <= ROLE_ADDR;
         bit_cnt_r   <= `BIT_CNT_RESET;
         shreg_r     <= 8'h00;
         tx_sh_r     <= `TX_IDLE_BYTE;
         ack_phase_r <= 1'b0;
         tx_mode_r   <= 1'b0;
         oe_n_r      <= 1'b1;
      end else if (start_det) begin
         state_r     <= ST_RX;
         role_r      <= ROLE_ADDR;
         bit_cnt_r   <= `BIT_CNT_RESET;
         ack_phase_r <= 1'b0;
         oe_n_r      <= 1'b1;
      end else if (stop_det) begin
         state_r <= ST_IDLE;
         oe_n_r  <= 1'b1;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               oe_n_r <= 1'b1;
            end
            ST_RX: begin
               if (scl_rise) begin
                  shreg_r <= rx_byte;
                  if (bit_cnt_r == `BYTE_LAST_BIT) begin
                     bit_cnt_r <= `BIT_CNT_RESET;
                     role_r    <= role_n;
                     if (role_r == ROLE_ADDR) begin
                        tx_mode_r <= tx_n;
                     end
                     if (acc) begin
                        state_r <= ST_ACK;
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end else begin
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (!ack_phase_r) begin
                     oe_n_r      <= 1'b0;
                     ack_phase_r <= 1'b1;
                  end else begin
                     ack_phase_r <= 1'b0;
                     bit_cnt_r   <= `BIT_CNT_RESET;
                     if (tx_mode_r) begin
                        oe_n_r  <= tx_hold_r[7];
                        tx_sh_r <= {tx_hold_r[6:0], 1'b1};
                        state_r <= ST_TX;
                     end else begin
                        oe_n_r  <= 1'b1;
                        state_r <= ST_RX;
                     end
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_r == `BYTE_BITS) begin
                     oe_n_r  <= 1'b1;
                     state_r <= ST_MACK;
                  end else begin
                     oe_n_r  <= tx_sh_r[7];
                     tx_sh_r <= {tx_sh_r[6:0], 1'b1};
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     state_r <= ST_IDLE;
                  end else begin
                     state_r <= ST_RELOAD;
                  end
               end
            end
            ST_RELOAD: begin
               if (scl_fall) begin
                  oe_n_r    <= tx_hold_r[7];
                  tx_sh_r   <= {tx_hold_r[6:0], 1'b1};
                  bit_cnt_r <= `BIT_CNT_RESET;
                  state_r   <= ST_TX;
               end
            end
         endcase
      end
   end

   // Command byte held for the capture, then flagged across
   always_ff @(posedge clk_link or negedge link_rst_n) begin
      if (!link_rst_n) begin
         cmd_r         <= 8'h00;
         cmd_tgl_r     <= 1'b0;
         cmd_code_l_r  <= 8'h00;
         cmd_param_l_r <= 8'h00;
      end else if (byte_done && acc) begin
         if (role_r == ROLE_CMD) begin
            cmd_r <= rx_byte;
         end
         if (emit) begin
            cmd_tgl_r <= ~cmd_tgl_r;
            if (role_r == ROLE_CMD) begin
               cmd_code_l_r  <= rx_byte;
               cmd_param_l_r <= 8'h00;
            end else begin
               cmd_code_l_r  <= cmd_r;
               cmd_param_l_r <= rx_byte;
            end
         end
      end
   end

   // Read pointer
   always_ff @(posedge clk_link or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ptr_r <= SEL_STATUS;
      end else if (byte_done && acc && ptr_load) begin
         ptr_r <= ptr_n;
      end
   end

   // Fresh snapshot requested for every byte the master will read
   always_ff @(posedge clk_link or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rd_req_tgl_r <= 1'b0;
      end else if ((byte_done && acc && role_r == ROLE_ADDR && tx_n) ||
                   (state_r == ST_MACK && scl_rise && !sda_s &&
                    !start_det && !stop_det)) begin
         rd_req_tgl_r <= ~rd_req_tgl_r;
      end
   end

   always_ff @(posedge clk_link or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rd_ack_seen_r <= 1'b0;
         tx_hold_r     <= `TX_IDLE_BYTE;
      end else if (rd_ack_s != rd_ack_seen_r) begin
         rd_ack_seen_r <= rd_ack_s;
         tx_hold_r     <= rd_data_r;
      end
   end

   assign sda_out  = 1'b0;
   assign sda_oe_n = oe_n_r;

   // System side: command events and register snapshots
   sync2 #(
      .WIDTH     (2),
      .RESET_VAL (2'b00)
   ) u_sys_sync (
      .clk   (clk_sys),
      .rst_n (nrst),
      .din   ({cmd_tgl_r, rd_req_tgl_r}),
      .dout  ({cmd_tgl_s, rd_req_s})
   );

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cmd_tgl_d_r <= 1'b0;
         cmd_valid_r <= 1'b0;
         cmd_code_r  <= 8'h00;
         cmd_param_r <= 8'h00;
      end else begin
         cmd_tgl_d_r <= cmd_tgl_s;
         cmd_valid_r <= cmd_tgl_s ^ cmd_tgl_d_r;
         if (cmd_tgl_s ^ cmd_tgl_d_r) begin
            cmd_code_r  <= cmd_code_l_r;
            cmd_param_r <= cmd_param_l_r;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_req_d_r   <= 1'b0;
         rd_data_r    <= `TX_IDLE_BYTE;
         rd_ack_tgl_r <= 1'b0;
      end else begin
         rd_req_d_r <= rd_req_s;
         if (rd_req_s ^ rd_req_d_r) begin
            unique case (ptr_r)
               SEL_STATUS:    rd_data_r <= status_byte;
               SEL_LINE_DATA: rd_data_r <= line_data_byte;
               SEL_CONFIG:    rd_data_r <= config_byte;
               SEL_CHANNEL:   rd_data_r <= channel_byte;
            endcase
            rd_ack_tgl_r <= ~rd_ack_tgl_r;
         end
      end
   end

   assign cmd_valid = cmd_valid_r;
   assign cmd_code  = cmd_code_r;
   assign cmd_param = cmd_param_r;

endmodule : i2c_host_command_port

// ---- sim/i2c_host_sva.sv ----
// Concurrent checks on the command port's pins and outputs.
// Assumes binding to i2c_host_command_port, map header on the include path.
`timescale 1ns/1ps
`include "i2c_host_map.svh"

module i2c_host_sva (
   input wire logic       clk_sys,
   input wire logic       nrst,
   input wire logic       clk_link,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_n,
   input wire logic       cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_param
);
   oe_scl_low_a: assert property (
      @(posedge clk_link) disable iff (!nrst)
      $changed(sda_oe_n) |-> !$past(scl_in) && !$past(scl_in, 2))
      else $error("data drive changed while clock high");
   start_quiet_a: assert property (
      @(posedge clk_link) disable iff (!nrst)
      scl_in && $past(scl_in) && $fell(sda_in) |-> sda_oe_n [*8])
      else $error("data pulled right after start");
   stop_quiet_a: assert property (
      @(posedge clk_link) disable iff (!nrst)
      scl_in && $past(scl_in) && $rose(sda_in) |-> sda_oe_n [*8])
      else $error("data pulled right after stop");
   open_drain_a: assert property (
      @(posedge clk_link) disable iff (!nrst)
      !sda_oe_n |-> sda_out == 1'b0)
      else $error("data driven high");
   valid_pulse_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      cmd_valid |=> !cmd_valid [*8])
      else $error("command strobe too long");
   code_hold_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      $changed(cmd_code) || $changed(cmd_param) |-> cmd_valid)
      else $error("command changed without strobe");
   code_legal_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      cmd_valid |-> cmd_code inside {`DEVICE_RESET_CMD, `CONFIG_WRITE_CMD,
         `CHANNEL_CHOOSE_CMD, `LINE_RESET_CMD, `LINE_BYTE_WRITE_CMD,
         `LINE_BYTE_READ_CMD, `LINE_SINGLE_BIT_CMD, `LINE_SEARCH_STEP_CMD})
      else $error("unknown command issued");
   chan_param_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      cmd_valid && cmd_code == `CHANNEL_CHOOSE_CMD |->
         cmd_param[7:4] == ~cmd_param[3:0] && !cmd_param[3])
      else $error("bad channel code issued");
   cfg_param_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      cmd_valid && cmd_code == `CONFIG_WRITE_CMD |->
         cmd_param[7:4] == ~cmd_param[3:0])
      else $error("bad config byte issued");
   cover property (@(posedge clk_sys) cmd_valid);
   cover property (@(posedge clk_link) $fell(sda_oe_n));
   cover property (@(posedge clk_sys)
      cmd_valid && cmd_code == `CHANNEL_CHOOSE_CMD);
endmodule : i2c_host_sva

bind i2c_host_command_port i2c_host_sva chk (
   .clk_sys   (clk_sys),
   .nrst      (nrst),
   .clk_link  (clk_link),
   .scl_in    (scl_in),
   .sda_in    (sda_in),
   .sda_out   (sda_out),
   .sda_oe_n  (sda_oe_n),
   .cmd_valid (cmd_valid),
   .cmd_code  (cmd_code),
   .cmd_param (cmd_param)
);

// ---- sim/i2c_master_model.sv ----
// Bus master model driving the command port's link.
// Assumes the bench forms the SDA wire level; SCL is driven push-pull.
`timescale 1ns/1ps

module i2c_master_model (
   input  wire logic clk_link,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   // 80 link cycles a bit, just under 400 kbit/s
   localparam int HALF = 40;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic bit_io(input logic b, output logic r);
      repeat (4) @(posedge clk_link);
      sda_low <= !b;
      repeat (HALF - 4) @(posedge clk_link);
      scl <= 1'b1;
      repeat (HALF / 2) @(posedge clk_link);
      r = sda;
      repeat (HALF / 2) @(posedge clk_link);
      scl <= 1'b0;
   endtask : bit_io

   task automatic start();
      repeat (4) @(posedge clk_link);
      sda_low <= 1'b0;
      repeat (HALF) @(posedge clk_link);
      scl <= 1'b1;
      repeat (HALF) @(posedge clk_link);
      sda_low <= 1'b1;
      repeat (HALF) @(posedge clk_link);
      scl <= 1'b0;
   endtask : start

   task automatic stop();
      repeat (4) @(posedge clk_link);
      sda_low <= 1'b1;
      repeat (HALF) @(posedge clk_link);
      scl <= 1'b1;
      repeat (HALF) @(posedge clk_link);
      sda_low <= 1'b0;
      repeat (HALF) @(posedge clk_link);
   endtask : stop

   // Ninth pulse always given, ack read in it
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask : wr_byte

   // Last wanted byte left without ack
   task automatic rd_byte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(!mack, r);
   endtask : rd_byte
endmodule : i2c_master_model

// ---- sim/testbench.sv ----
// Self-checking bench of the command port.
// Assumes the design package, map header and the bus master model.
`timescale 1ns/1ps
`include "i2c_host_map.svh"

module testbench;
   typedef struct packed {
      logic       busy;
      logic [7:0] code;
      logic       np;
      logic [7:0] param;
      logic       ack_c;
      logic       ack_p;
      logic       fire;
   } row_s;
   localparam logic [6:0] SADDR = {`ADDR_HI_DEFAULT, 3'b101};
   localparam int         NROW  = 14;
   localparam row_s       ROWS [NROW] = '{
      '{1'b0, `DEVICE_RESET_CMD, 1'b0, 8'h00, 1'b1, 1'b0, 1'b1},
      '{1'b0, `CONFIG_WRITE_CMD, 1'b1, 8'hA5, 1'b1, 1'b1, 1'b1},
      '{1'b0, `CHANNEL_CHOOSE_CMD, 1'b1, 8'hE1, 1'b1, 1'b1, 1'b1},
      '{1'b0, `CHANNEL_CHOOSE_CMD, 1'b1, 8'hE5, 1'b1, 1'b0, 1'b0},
      '{1'b0, `LINE_RESET_CMD, 1'b0, 8'h00, 1'b1, 1'b0, 1'b1},
      '{1'b0, `LINE_BYTE_WRITE_CMD, 1'b1, 8'h33, 1'b1, 1'b1, 1'b1},
      '{1'b0, `LINE_BYTE_READ_CMD, 1'b0, 8'h00, 1'b1, 1'b0, 1'b1},
      '{1'b0, `LINE_SINGLE_BIT_CMD, 1'b1, 8'h80, 1'b1, 1'b1, 1'b1},
      '{1'b0, `LINE_SEARCH_STEP_CMD, 1'b1, 8'h80, 1'b1, 1'b1, 1'b1},
      '{1'b0, 8'h11, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0},
      '{1'b1, `CONFIG_WRITE_CMD, 1'b1, 8'hA5, 1'b0, 1'b0, 1'b0},
      '{1'b1, `LINE_RESET_CMD, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0},
      '{1'b1, `DEVICE_RESET_CMD, 1'b0, 8'h00, 1'b1, 1'b0, 1'b1},
      '{1'b0, `POINTER_SET_CMD, 1'b1, 8'hE5, 1'b1, 1'b0, 1'b0}};

   logic       clk_sys  = 1'b0;
   logic       clk_link = 1'b0;
   logic       nrst     = 1'b0;
   logic       busy     = 1'b0;
   logic [2:0] pins     = 3'b101;
   logic       scl, sda_low, sda, sda_out, sda_oe_n, cmd_valid;
   logic [7:0] cmd_code, cmd_param;
   int         n_mismatch = 0;
   int         tests_run  = 0;
   int         n_cmd      = 0;
   int         cyc        = 0;

   always #5 clk_sys = ~clk_sys;
   always #16 clk_link = ~clk_link;
   assign sda = !sda_low && !(!sda_oe_n && !sda_out);

   i2c_host_command_port DUT (
      .clk_sys           (clk_sys),
      .nrst              (nrst),
      .clk_link          (clk_link),
      .scl_in            (scl),
      .sda_in            (sda),
      .sda_out           (sda_out),
      .sda_oe_n          (sda_oe_n),
      .addr_select_pin_0 (pins[0]),
      .addr_select_pin_1 (pins[1]),
      .addr_select_pin_2 (pins[2]),
      .line_busy_flag    (busy),
      .status_byte       (8'h5C),
      .line_data_byte    (8'hA3),
      .config_byte       (8'h96),
      .channel_byte      (8'h3E),
      .cmd_valid         (cmd_valid),
      .cmd_code          (cmd_code),
      .cmd_param         (cmd_param)
   );

   i2c_master_model host (
      .clk_link (clk_link),
      .sda      (sda),
      .scl      (scl),
      .sda_low  (sda_low)
   );

   task automatic stop_test();
      $display("Compares %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test

   task automatic chk_bit(input logic g, e, input string s);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, s);
      end
   endtask : chk_bit

   task automatic chk_byte(input logic [7:0] g, e, input string s);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: %s %h", $time, s, g);
      end
   endtask : chk_byte

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cmd_valid === 1'b1)
         n_cmd <= n_cmd + 1;
      if (cyc == 200000) begin
         n_mismatch = n_mismatch + 1;
         stop_test();
      end
   end

   task automatic xfer(input row_s r);
      logic a;
      int   n0;
      @(posedge clk_sys);
      busy <= r.busy;
      repeat (8) @(posedge clk_sys);
      n0 = n_cmd;
      host.start();
      host.wr_byte({SADDR, 1'b0}, a);
      chk_bit(a, 1'b1, "write address ack");
      host.wr_byte(r.code, a);
      chk_bit(a, r.ack_c, "code ack");
      if (r.np && r.ack_c) begin
         host.wr_byte(r.param, a);
         chk_bit(a, r.ack_p, "param ack");
      end
      host.stop();
      repeat (40) @(posedge clk_sys);
      chk_bit(n_cmd == n0 + r.fire, 1'b1, "command count");
      if (r.fire) begin
         chk_byte(cmd_code, r.code, "code");
         chk_byte(cmd_param, r.np ? r.param : 8'h00, "param");
      end
   endtask : xfer

   task automatic rd(input logic [7:0] exp, input int n);
      logic       a;
      logic [7:0] d;
      host.start();
      host.wr_byte({SADDR, 1'b1}, a);
      chk_bit(a, 1'b1, "read address ack");
      for (int i = 0; i < n; i++) begin
         host.rd_byte(i < n - 1, d);
         chk_byte(d, exp, "read data");
      end
      host.stop();
   endtask : rd

   initial begin
      logic a;
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (100) @(posedge clk_sys);
      for (int i = 0; i < NROW; i++)
         xfer(ROWS[i]);
      rd(8'h5C, 2);
      xfer('{1'b0, `POINTER_SET_CMD, 1'b1, `PTR_CONFIG, 1'b1, 1'b1,
             1'b0});
      rd(8'h96, 2);
      host.start();
      host.wr_byte({SADDR, 1'b0}, a);
      host.wr_byte(`POINTER_SET_CMD, a);
      host.wr_byte(`PTR_CHANNEL, a);
      chk_bit(a, 1'b1, "pointer ack");
      rd(8'h3E, 1);
      xfer('{1'b0, `POINTER_SET_CMD, 1'b1, `PTR_LINE_DATA, 1'b1, 1'b1,
             1'b0});
      rd(8'hA3, 1);
      @(posedge clk_sys);
      pins <= 3'b111;
      repeat (20) @(posedge clk_sys);
      host.start();
      host.wr_byte({SADDR, 1'b0}, a);
      chk_bit(a, 1'b0, "old address ack");
      host.stop();
      host.start();
      host.wr_byte({`ADDR_HI_DEFAULT, 3'b111, 1'b0}, a);
      chk_bit(a, 1'b1, "new address ack");
      host.wr_byte(`LINE_RESET_CMD, a);
      chk_bit(a, 1'b1, "code ack");
      host.wr_byte(8'h55, a);
      chk_bit(a, 1'b0, "surplus ack");
      host.stop();
      repeat (40) @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk_bit(sda_oe_n, 1'b1, "reset drive");
      chk_bit(cmd_valid, 1'b0, "reset strobe");
      chk_byte(cmd_code, 8'h00, "reset code");
      chk_byte(cmd_param, 8'h00, "reset param");
      stop_test();
   end
endmodule : testbench
